// ### rtl/pwp_pkg.sv
// Package of offsets, field positions and reset values for the peripheral write protector.
package pwp_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets, byte addresses on the register port.
  localparam logic [7:0] OFF_B0_CLR = 8'h00;
  localparam logic [7:0] OFF_B0_SET = 8'h04;
  localparam logic [7:0] OFF_B1_CLR = 8'h10;
  localparam logic [7:0] OFF_B1_SET = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // Protect bit positions of bank 0.
  localparam int B0_EXT_INTERRUPT_UNIT = 6;
  localparam int B0_CALENDAR_TIMER_UNIT = 5;
  localparam int B0_WATCHDOG_UNIT = 4;
  localparam int B0_CLOCK_GENERATOR_UNIT = 3;
  localparam int B0_SYSTEM_CONTROL_UNIT = 2;
  localparam int B0_POWER_MANAGER_UNIT = 1;

  // Protect bit positions of bank 1.
  localparam int B1_TRACE_BUFFER_UNIT = 6;
  localparam int B1_IO_PORT_UNIT = 3;
  localparam int B1_FLASH_CONTROLLER_UNIT = 2;
  localparam int B1_DEBUG_UNIT = 1;

  // Implemented protect bits and reset values of each bank.
  localparam logic [7:0] IMPL_B0 = 8'h7E;
  localparam logic [7:0] IMPL_B1 = 8'h4E;
  localparam logic [7:0] RST_B0 = 8'h00;
  localparam logic [7:0] RST_B1 = 8'h02;

  // Interrupt status bit positions and reset values.
  localparam int EV_W = 3;
  localparam int EV_DOUBLE_PROTECT = 0;
  localparam int EV_DOUBLE_UNPROTECT = 1;
  localparam int EV_BLOCKED_WRITE = 2;
  localparam logic [2:0] RST_IRQ_STAT = 3'h0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

endpackage

// ### rtl/pwp_peripheral_write_protect.sv
// Peripheral write protector with two banks of protect bits and an interrupt block.
//
// Notes on behaviour
// R01: Writing zero leaves protection unchanged.
// R02: Clear register one removes protection.
// R03: Bit reads 1 protected, 0 unprotected.
// R04: Bank 0 set register 0x04, resets zero.
// R05: Bank 1 clear register 0x10, debug protected.
// R06: Bank 1 bits 6,3,2,1; others unused.
// R07: Bank 0 bits read/write, reset to 0.
// R08: Set register one protects; both read same.
// R09: Write to protected peripheral blocked, errors.
// R10: Double protect or unprotect gives error.
// R11: Byte, halfword and word accesses accepted.
// R12: Simultaneous set and clear: clear wins.
`timescale 1ns/100ps

module pwp_peripheral_write_protect #(
  parameter int BANK_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data_q,
  output logic bus_err_q,
  output logic irq_q,
  output logic [15:0] protect_q,
  input wire logic [15:0] periph_wr_req,
  output logic [15:0] periph_wr_ok_q,
  output logic [15:0] periph_wr_err_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // Each bank occupies the low byte of its register; other widths are refused.
  if (BANK_W != 8) begin : g_bad_width
    $error("BANK_W must be 8.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and byte lanes.

  // Byte enables mask the write data so partial accesses touch only their lanes.
  logic [31:0] lane_mask;
  logic [31:0] wd;
  assign lane_mask = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}}; // R11
  assign wd = wr_data & lane_mask; // R11

  // Register selects.
  logic sel_b0_clr;
  logic sel_b0_set;
  logic sel_b1_clr;
  logic sel_b1_set;
  logic sel_stat;
  logic sel_mask;
  logic sel_any;
  assign sel_b0_clr = (addr == pwp_pkg::OFF_B0_CLR);
  assign sel_b0_set = (addr == pwp_pkg::OFF_B0_SET); // R04
  assign sel_b1_clr = (addr == pwp_pkg::OFF_B1_CLR); // R05
  assign sel_b1_set = (addr == pwp_pkg::OFF_B1_SET);
  assign sel_stat = (addr == pwp_pkg::OFF_IRQ_STAT);
  assign sel_mask = (addr == pwp_pkg::OFF_IRQ_MASK);
  assign sel_any = sel_b0_clr | sel_b0_set | sel_b1_clr | sel_b1_set | sel_stat | sel_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // Protect bit update.

  // Implemented positions of both banks; bank 1 sits in the upper byte.
  logic [15:0] impl_mask;
  assign impl_mask = {pwp_pkg::IMPL_B1, pwp_pkg::IMPL_B0}; // R06

  // Ones written to a clear or set register, restricted to implemented bits; zeros do nothing.
  logic [15:0] clr_bits;
  logic [15:0] set_bits;
  assign clr_bits = impl_mask & {
    (wr_stb && sel_b1_clr) ? wd[7:0] : 8'h00,
    (wr_stb && sel_b0_clr) ? wd[7:0] : 8'h00}; // R01 R02
  assign set_bits = impl_mask & {
    (wr_stb && sel_b1_set) ? wd[7:0] : 8'h00,
    (wr_stb && sel_b0_set) ? wd[7:0] : 8'h00}; // R01 R08

  // Next protection state; a clear beats a set aimed at the same bit.
  logic [15:0] protect_d;
  assign protect_d = (protect_q | set_bits) & ~clr_bits; // R12 R02 R08

  // Second protect or second unprotect of the same peripheral is a program-flow fault.
  logic dbl_protect;
  logic dbl_unprotect;
  assign dbl_protect = |(set_bits & protect_q); // R10
  assign dbl_unprotect = |(clr_bits & ~protect_q); // R10

  // Protect bits; bank 0 starts open, bank 1 starts with the debug unit locked.
  always_ff @(posedge mclk) begin
    if (rst) begin
      protect_q <= {pwp_pkg::RST_B1, pwp_pkg::RST_B0}; // R05 R07
    end else begin
      protect_q <= protect_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral write gating.

  // Each peripheral write is passed or refused one cycle later by its protect bit.
  for (genvar i = 0; i < 16; i++) begin : g_gate
    always_ff @(posedge mclk) begin
      if (rst) begin
        periph_wr_ok_q[i] <= 1'b0;
        periph_wr_err_q[i] <= 1'b0;
      end else begin
        periph_wr_ok_q[i] <= periph_wr_req[i] & ~protect_q[i]; // R09
        periph_wr_err_q[i] <= periph_wr_req[i] & protect_q[i]; // R09
      end
    end
  end

  logic blocked_write;
  assign blocked_write = |(periph_wr_req & protect_q); // R09

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic [2:0] events;
  logic [2:0] stat_clr;

  // Events set sticky bits; a set in the same cycle as a write-one clear wins.
  assign events[pwp_pkg::EV_DOUBLE_PROTECT] = dbl_protect;
  assign events[pwp_pkg::EV_DOUBLE_UNPROTECT] = dbl_unprotect;
  assign events[pwp_pkg::EV_BLOCKED_WRITE] = blocked_write;
  assign stat_clr = (wr_stb && sel_stat) ? wd[2:0] : 3'h0;
  assign stat_d = (stat_q & ~stat_clr) | events;
  assign mask_d = (wr_stb && sel_mask) ? wd[2:0] : mask_q;

  // Status, mask and the level interrupt.
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_q <= pwp_pkg::RST_IRQ_STAT;
      mask_q <= pwp_pkg::RST_IRQ_MASK;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path and bus error.

  // Clear and set registers of a bank return the same protect bits.
  logic [31:0] rd_mux;
  assign rd_mux =
    (sel_b0_clr | sel_b0_set) ? {24'h000000, protect_q[7:0]} : // R03 R08
    (sel_b1_clr | sel_b1_set) ? {24'h000000, protect_q[15:8]} : // R03 R08
    sel_stat ? {29'h0, stat_q} :
    sel_mask ? {29'h0, mask_q} :
    32'h00000000;

  // Bus error marks a double protect, double unprotect or unmapped access.
  logic bus_err_d;
  assign bus_err_d = (wr_stb & (dbl_protect | dbl_unprotect | ~sel_any)) |
                     (rd_stb & ~sel_any); // R10

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_q <= 32'h00000000;
      bus_err_q <= 1'b0;
    end else begin
      rd_data_q <= rd_stb ? rd_mux : 32'h00000000;
      bus_err_q <= bus_err_d;
    end
  end

endmodule // pwp_peripheral_write_protect

// ### dv/pwp_props.sv
// Checker of the write protector register and gate ports.
`timescale 1ns/100ps
module pwp_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rd_data_q,
  input wire logic bus_err_q,
  input wire logic [15:0] protect_q,
  input wire logic [15:0] periph_wr_req,
  input wire logic [15:0] periph_wr_ok_q,
  input wire logic [15:0] periph_wr_err_q
);
  // One clock domain; reset disables every check.
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence set_wr; wr_stb && wr_be[0] && addr == 8'h04; endsequence
  sequence clr_wr; wr_stb && wr_be[0] && addr == 8'h10; endsequence
  set_read_a: assert property (rd_stb && addr == 8'h04 |-> ##1
    rd_data_q == {24'h0, $past(protect_q[7:0])}) else $error("set read wrong");
  set_bit_a: assert property (set_wr |=> (protect_q[7:0] & $past(wr_data[7:0])
    & 8'h7E) == ($past(wr_data[7:0]) & 8'h7E)) else $error("set bit lost");
  clr_bit_a: assert property (clr_wr |=>
    (protect_q[15:8] & $past(wr_data[7:0])) == 8'h00) else $error("clear bit lost");
  zero_keep_a: assert property (wr_stb && (wr_data[7:0] == 8'h00 || !wr_be[0])
    |=> $stable(protect_q)) else $error("protect changed");
  block_err_a: assert property (##1 periph_wr_err_q ==
    ($past(periph_wr_req) & $past(protect_q))) else $error("gate error wrong");
  pass_ok_a: assert property (##1 periph_wr_ok_q ==
    ($past(periph_wr_req) & ~$past(protect_q))) else $error("gate pass wrong");
  dbl_set_a: assert property (set_wr and ##0 (|(wr_data[7:0] & protect_q[7:0]
    & 8'h7E)) |=> bus_err_q) else $error("double protect silent");
  dbl_clr_a: assert property (clr_wr and ##0 (|(wr_data[7:0] & ~protect_q[15:8]
    & 8'h4E)) |=> bus_err_q) else $error("double unprotect silent");
endmodule // pwp_props

// ### dv/pwp_periph_model.sv
// Model of the peripherals that attempt writes through the gate.
`timescale 1ns/100ps
module pwp_periph_model (
  input wire logic mclk,
  output logic [15:0] periph_wr_req
);
  initial periph_wr_req = 16'h0000;
  // Raises a set of write attempts for exactly one cycle.
  task automatic pulse(input logic [15:0] v);
    @(posedge mclk);
    periph_wr_req <= v;
    @(posedge mclk);
    periph_wr_req <= 16'h0000;
    #1;
  endtask
endmodule // pwp_periph_model

// ### dv/testbench.sv
// Self-checking bench for the peripheral write protector.
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [3:0] wr_be = 4'hF;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data_q;
  logic bus_err_q;
  logic irq_q;
  logic [15:0] protect_q;
  logic [15:0] periph_wr_req;
  logic [15:0] periph_wr_ok_q;
  logic [15:0] periph_wr_err_q;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // Clock of 10 ns period.
  always #5 mclk = ~mclk;
  pwp_peripheral_write_protect uut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_be(wr_be), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
    .bus_err_q(bus_err_q), .irq_q(irq_q), .protect_q(protect_q), .periph_wr_req(periph_wr_req),
    .periph_wr_ok_q(periph_wr_ok_q), .periph_wr_err_q(periph_wr_err_q));
  pwp_periph_model pm (.mclk(mclk), .periph_wr_req(periph_wr_req));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  // One strobe cycle; the answer is sampled in the cycle after it.
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    rd_stb <= rd;
    wr_stb <= !rd;
    @(posedge mclk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    bus(1'b1, 8'h04, 32'h0);
    chk("bank0", 32'h0, rd_data_q);
    bus(1'b1, 8'h10, 32'h0);
    chk("bank1", 32'h2, rd_data_q);
  endtask
  task automatic t_bank0;
    bus(1'b0, 8'h04, 32'h7E);
    chk("err", 32'h0, {31'h0, bus_err_q});
    bus(1'b1, 8'h00, 32'h0);
    chk("clr_rd", 32'h7E, rd_data_q);
    bus(1'b0, 8'h04, 32'h10);
    chk("dbl", 32'h1, {31'h0, bus_err_q});
    @(posedge mclk) wr_be <= 4'hE;
    bus(1'b0, 8'h00, 32'h7E);
    @(posedge mclk) wr_be <= 4'hF;
    bus(1'b0, 8'h00, 32'h0);
    chk("keep", 32'h7E, {24'h0, protect_q[7:0]});
    bus(1'b0, 8'h00, 32'h4);
    chk("clr", 32'h7A, {24'h0, protect_q[7:0]});
    bus(1'b0, 8'h00, 32'h4);
    chk("dbl_clr", 32'h1, {31'h0, bus_err_q});
  endtask
  task automatic t_bank1_gate;
    bus(1'b0, 8'h14, 32'hFF);
    chk("bank1", 32'h4E, {24'h0, protect_q[15:8]});
    bus(1'b0, 8'h24, 32'h4);
    pm.pulse(16'h0206);
    chk("err_q", 32'h0202, {16'h0, periph_wr_err_q});
    chk("ok_q", 32'h0004, {16'h0, periph_wr_ok_q});
    chk("irq", 32'h1, {31'h0, irq_q});
    bus(1'b0, 8'h20, 32'h4);
    chk("irq_clr", 32'h0, {31'h0, irq_q});
    bus(1'b0, 8'h10, 32'h40);
    chk("b1_clr", 32'h0E, {24'h0, protect_q[15:8]});
    bus(1'b0, 8'h10, 32'h40);
    chk("b1_dbl_clr", 32'h1, {31'h0, bus_err_q});
    bus(1'b1, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, bus_err_q});
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      num_errors++;
      end_of_test();
    end
  end
  // Main sequence after four reset cycles.
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_bank0();
    t_bank1_gate();
    end_of_test();
  end
endmodule // testbench
bind pwp_peripheral_write_protect pwp_props u_props (.mclk(mclk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_be(wr_be), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
  .bus_err_q(bus_err_q), .protect_q(protect_q), .periph_wr_req(periph_wr_req),
  .periph_wr_ok_q(periph_wr_ok_q), .periph_wr_err_q(periph_wr_err_q));
